// *** cbt_bit_timing.sv ***
// Bit-timing engine with synchronisation and error-flag timing for one bus node.
// Assumes a same-clock frame controller supplies error events and transmit bits,
// and that the receive pin is asynchronous to ref_clk_in.
//
// The implementer's own choices: strobed register access and the register offsets.

module cbt_bit_timing (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wr_data_in,
    input  wire logic        wr_en_in,
    input  wire logic        rd_en_in,
    output logic      [31:0] rd_data_out,
    // Bus pins
    input  wire logic        can_rx_in,
    output logic             can_tx_out,
    // Frame controller
    input  wire logic        bus_idle_in,
    input  wire logic        tx_active_in,
    input  wire logic        tx_bit_in,
    input  wire logic        tx_start_in,
    input  wire logic        error_passive_in,
    input  wire logic        err_now_in,
    input  wire logic        err_crc_in,
    input  wire logic        ack_delim_in,
    output logic             sample_out,
    output logic             sampled_bit_out,
    output logic             bit_start_out,
    output logic             err_flag_out,
    output logic             retransmit_out
);

    cbt_tq_if tq ();

    cbt_prescaler u_prescaler (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .tq         (tq)
    );

    logic [31:0]        cfg_r;
    logic [1:0]         rx_sync_r;
    logic               rx_prev_r;
    cbt_pkg::cbt_state_t state_r;
    logic [4:0]         tq_cnt_r;
    logic [4:0]         pb1_ext_r;
    logic [4:0]         pb2_cut_r;
    logic               synced_r;
    logic               flag_pend_r;
    logic               crc_pend_r;
    logic               flag_on_r;
    logic [2:0]         flag_cnt_r;
    logic               flag_tx_r;

    logic               rx;
    logic [4:0]         prop_len;
    logic [4:0]         pb1_len;
    logic [4:0]         sjw_len;
    logic [4:0]         pb2_base;
    logic [4:0]         pb1_eff;
    logic [4:0]         pb2_eff;
    logic [4:0]         bit_len;
    logic               cfg_ok;
    logic               fall_edge;
    logic               hard_sync;
    logic               resync;
    logic [4:0]         late_err;
    logic [4:0]         early_err;
    logic               tick;
    logic               sample_pt;
    logic               bit_end;

    assign rx       = rx_sync_r[1];
    assign tick     = tq.tq_tick;
    assign prop_len = {1'b0, cfg_r[cbt_pkg::CFG_PROP_LSB +: 4]};
    assign pb1_len  = {1'b0, cfg_r[cbt_pkg::CFG_PB1_LSB +: 4]};
    assign sjw_len  = {2'b00, cfg_r[cbt_pkg::CFG_SJW_LSB +: 3]};
    assign tq.prescale = cfg_r[cbt_pkg::CFG_PRESC_LSB +: 8];

    assign pb2_base = (pb1_len < cbt_pkg::IPT_TQ) ? cbt_pkg::IPT_TQ : pb1_len;
    assign pb1_eff  = pb1_len + pb1_ext_r;
    assign pb2_eff  = pb2_base - pb2_cut_r;
    assign bit_len  = cbt_pkg::SYNC_TQ + prop_len + pb1_len + pb2_base;

    assign cfg_ok = cfg_r[cbt_pkg::CFG_EN_BIT]
                  && prop_len >= cbt_pkg::PROP_MIN_TQ && prop_len <= cbt_pkg::PROP_MAX_TQ
                  && pb1_len >= cbt_pkg::PB1_MIN_TQ && pb1_len <= cbt_pkg::PB1_MAX_TQ
                  && pb2_base <= cbt_pkg::PB2_MAX_TQ
                  && sjw_len >= cbt_pkg::SJW_MIN_TQ && sjw_len <= cbt_pkg::SJW_MAX_TQ
                  && sjw_len <= pb1_len
                  && bit_len >= cbt_pkg::BIT_MIN_TQ && bit_len <= cbt_pkg::BIT_MAX_TQ;

    // level must differ from last sample
    assign fall_edge = rx_prev_r && !rx && (rx != sampled_bit_out);

    assign hard_sync = cfg_ok && fall_edge && (state_r == cbt_pkg::ST_IDLE || bus_idle_in);
    // one resync per bit
    // Own dominant bit seen late is not a timing error, so transmitting dominant blocks resync
    assign resync = cfg_ok && fall_edge && !hard_sync && !synced_r
                  && state_r != cbt_pkg::ST_SYNC
                  && !(tx_active_in && can_tx_out == cbt_pkg::DOMINANT);

    assign late_err  = (state_r == cbt_pkg::ST_PROP) ? tq_cnt_r + 5'h01
                                                     : prop_len + tq_cnt_r + 5'h01;
    assign early_err = pb2_eff - tq_cnt_r;

    assign sample_pt = tick && state_r == cbt_pkg::ST_PB1 && tq_cnt_r + 5'h01 >= pb1_eff;
    assign bit_end   = (tick && state_r == cbt_pkg::ST_PB2 && tq_cnt_r + 5'h01 >= pb2_eff)
                     || (tq.restart && state_r == cbt_pkg::ST_PB2);

    // Restart the quantum grid so the start edge sits at the beginning of sync
    assign tq.restart = hard_sync
                      || (resync && state_r == cbt_pkg::ST_PB2 && early_err <= sjw_len);

    // Receive pin synchroniser
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_sync_r <= {cbt_pkg::RECESSIVE, cbt_pkg::RECESSIVE};
            rx_prev_r <= cbt_pkg::RECESSIVE;
        end else begin
            rx_sync_r <= {rx_sync_r[0], can_rx_in};
            rx_prev_r <= rx;
        end
    end

    // Register writes
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cfg_r <= cbt_pkg::CFG_RESET;
        end else if (wr_en_in && addr_in == cbt_pkg::CFG_OFFSET) begin
            cfg_r <= wr_data_in;
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_out <= 32'h0000_0000;
        end else if (rd_en_in) begin
            case (addr_in)
                cbt_pkg::CFG_OFFSET:    rd_data_out <= cfg_r;
                cbt_pkg::STATUS_OFFSET: begin
                    rd_data_out <= 32'h0000_0000;
                    rd_data_out[cbt_pkg::ST_STATE_LSB +: 3] <= state_r;
                    rd_data_out[cbt_pkg::ST_SAMPLE_BIT]     <= sampled_bit_out;
                    rd_data_out[cbt_pkg::ST_CFG_OK_BIT]     <= cfg_ok;
                    rd_data_out[cbt_pkg::ST_FLAG_BIT]       <= flag_on_r;
                    rd_data_out[cbt_pkg::ST_RETX_BIT]       <= retransmit_out;
                    rd_data_out[cbt_pkg::ST_RX_BIT]         <= rx;
                end
                default:                rd_data_out <= 32'h0000_0000;
            endcase
        end else begin
            rd_data_out <= 32'h0000_0000;
        end
    end

    // Segment sequencer
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r   <= cbt_pkg::ST_IDLE;
            tq_cnt_r  <= 5'h00;
            pb1_ext_r <= 5'h00;
            pb2_cut_r <= 5'h00;
        end else if (!cfg_ok) begin
            state_r   <= cbt_pkg::ST_IDLE;
            tq_cnt_r  <= 5'h00;
            pb1_ext_r <= 5'h00;
            pb2_cut_r <= 5'h00;
        end else if (tq.restart) begin
            state_r   <= cbt_pkg::ST_SYNC;
            tq_cnt_r  <= 5'h00;
            pb1_ext_r <= 5'h00;
            pb2_cut_r <= 5'h00;
        end else begin
            if (resync && state_r == cbt_pkg::ST_PB2) begin
                pb2_cut_r <= sjw_len;
            end else if (resync) begin
                pb1_ext_r <= (late_err > sjw_len) ? sjw_len : late_err;
            end
            if (tick) begin
                case (state_r)
                    cbt_pkg::ST_IDLE: begin
                        tq_cnt_r <= 5'h00;
                    end
                    cbt_pkg::ST_SYNC: begin
                        state_r  <= cbt_pkg::ST_PROP;
                        tq_cnt_r <= 5'h00;
                    end
                    cbt_pkg::ST_PROP: begin
                        if (tq_cnt_r + 5'h01 >= prop_len) begin
                            state_r  <= cbt_pkg::ST_PB1;
                            tq_cnt_r <= 5'h00;
                        end else begin
                            tq_cnt_r <= tq_cnt_r + 5'h01;
                        end
                    end
                    cbt_pkg::ST_PB1: begin
                        if (sample_pt) begin
                            state_r   <= cbt_pkg::ST_PB2;
                            tq_cnt_r  <= 5'h00;
                            pb1_ext_r <= 5'h00;
                        end else begin
                            tq_cnt_r <= tq_cnt_r + 5'h01;
                        end
                    end
                    cbt_pkg::ST_PB2: begin
                        if (bit_end) begin
                            state_r   <= cbt_pkg::ST_SYNC;
                            tq_cnt_r  <= 5'h00;
                            pb2_cut_r <= 5'h00;
                        end else begin
                            tq_cnt_r <= tq_cnt_r + 5'h01;
                        end
                    end
                    default: begin
                        state_r  <= cbt_pkg::ST_IDLE;
                        tq_cnt_r <= 5'h00;
                    end
                endcase
            end
        end
    end

    // Sampling and one-sync-per-bit bookkeeping
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            sampled_bit_out <= cbt_pkg::RECESSIVE;
            sample_out      <= 1'b0;
            synced_r        <= 1'b0;
        end else begin
            sample_out <= sample_pt;
            if (sample_pt) begin
                sampled_bit_out <= rx;
            end
            if (sample_pt) begin
                synced_r <= 1'b0;
            end else if (hard_sync || resync) begin
                synced_r <= 1'b1;
            end
        end
    end

    // Error flag scheduling
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            flag_pend_r <= 1'b0;
            crc_pend_r  <= 1'b0;
            flag_on_r   <= 1'b0;
            flag_cnt_r  <= 3'h0;
            flag_tx_r   <= 1'b0;
        end else begin
            if (err_crc_in) begin
                crc_pend_r <= 1'b1;
            end else if (ack_delim_in && crc_pend_r) begin
                crc_pend_r <= 1'b0;
            end
            if (err_now_in || (ack_delim_in && crc_pend_r)) begin
                flag_pend_r <= 1'b1;
                flag_tx_r   <= flag_tx_r | tx_active_in;
            end else if (bit_end && flag_pend_r) begin
                flag_pend_r <= 1'b0;
            end
            if (bit_end && flag_pend_r && !flag_on_r) begin
                flag_on_r  <= 1'b1;
                flag_cnt_r <= 3'h0;
            end else if (bit_end && flag_on_r) begin
                if (flag_cnt_r + 3'h1 >= cbt_pkg::ERR_FLAG_BITS) begin
                    flag_on_r <= 1'b0;
                    flag_tx_r <= 1'b0;
                end else begin
                    flag_cnt_r <= flag_cnt_r + 3'h1;
                end
            end
        end
    end

    // Transmit pin, flag output and retransmission request
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            can_tx_out     <= cbt_pkg::RECESSIVE;
            bit_start_out  <= 1'b0;
            err_flag_out   <= 1'b0;
            retransmit_out <= 1'b0;
        end else begin
            bit_start_out <= bit_end;
            err_flag_out  <= flag_on_r;
            if (bit_end) begin
                if (flag_pend_r || (flag_on_r && flag_cnt_r + 3'h1 < cbt_pkg::ERR_FLAG_BITS)) begin
                    can_tx_out <= error_passive_in ? cbt_pkg::RECESSIVE : cbt_pkg::DOMINANT;
                end else if (tx_active_in) begin
                    can_tx_out <= tx_bit_in;
                end else begin
                    can_tx_out <= cbt_pkg::RECESSIVE;
                end
            end else if (!cfg_ok) begin
                can_tx_out <= cbt_pkg::RECESSIVE;
            end
            if (bit_end && flag_on_r && flag_tx_r && flag_cnt_r + 3'h1 >= cbt_pkg::ERR_FLAG_BITS) begin
                retransmit_out <= 1'b1;
            end else if (tx_start_in) begin
                retransmit_out <= 1'b0;
            end
        end
    end

endmodule

// *** cbt_pkg.sv ***
// Constants, register map and state encodings of the bit-timing and error-flag block.
// Assumes a single 100 MHz clock and a same-clock frame controller beside the block.
package cbt_pkg;

    // Register offsets (byte addresses on the plain register port)
    localparam logic [7:0]  CFG_OFFSET        = 8'h00;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h04;

    // Configuration register fields
    localparam int          CFG_PRESC_LSB     = 0;
    localparam int          CFG_PROP_LSB      = 8;
    localparam int          CFG_PB1_LSB       = 12;
    localparam int          CFG_SJW_LSB       = 16;
    localparam int          CFG_EN_BIT        = 31;
    localparam logic [31:0] CFG_RESET         = 32'h0000_0000;

    // Status register fields
    localparam int          ST_STATE_LSB      = 0;
    localparam int          ST_SAMPLE_BIT     = 3;
    localparam int          ST_CFG_OK_BIT     = 4;
    localparam int          ST_FLAG_BIT       = 5;
    localparam int          ST_RETX_BIT       = 6;
    localparam int          ST_RX_BIT         = 7;

    // Segment limits, in time quanta
    localparam logic [4:0]  SYNC_TQ           = 5'h01;
    localparam logic [4:0]  PROP_MIN_TQ       = 5'h01;
    localparam logic [4:0]  PROP_MAX_TQ       = 5'h08;
    localparam logic [4:0]  PB1_MIN_TQ        = 5'h01;
    localparam logic [4:0]  PB1_MAX_TQ        = 5'h08;
    localparam logic [4:0]  PB2_MAX_TQ        = 5'h08;
    localparam logic [4:0]  SJW_MIN_TQ        = 5'h01;
    localparam logic [4:0]  SJW_MAX_TQ        = 5'h04;
    localparam logic [4:0]  BIT_MIN_TQ        = 5'h08;
    localparam logic [4:0]  BIT_MAX_TQ        = 5'h19;
    localparam logic [4:0]  IPT_TQ            = 5'h02;

    // Error flag length in bits
    localparam logic [2:0]  ERR_FLAG_BITS     = 3'h6;

    // Bus levels
    localparam logic        RECESSIVE         = 1'b1;
    localparam logic        DOMINANT          = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_PROP = 3'b010,
        ST_PB1  = 3'b011,
        ST_PB2  = 3'b100
    } cbt_state_t;

endpackage

// *** cbt_tq_if.sv ***
// Link between the bit-timing engine and its time-quantum prescaler.
// Assumes both ends run on the same clock.
interface cbt_tq_if;
    logic [7:0] prescale;
    logic       restart;
    logic       tq_tick;

    modport engine    (output prescale, output restart, input tq_tick);
    modport prescaler (input prescale, input restart, output tq_tick);
endinterface

// *** cbt_prescaler.sv ***
// Time-quantum prescaler: one tick every (prescale + 1) system clocks.
// Assumes the engine pulses restart to realign the quantum grid.
module cbt_prescaler (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic reset_in,
    // Engine side
    cbt_tq_if.prescaler tq
);

    logic [7:0] div_cnt_r;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            div_cnt_r  <= 8'h00;
            tq.tq_tick <= 1'b0;
        end else if (tq.restart) begin
            div_cnt_r  <= 8'h00;
            tq.tq_tick <= 1'b0;
        end else if (div_cnt_r >= tq.prescale) begin
            div_cnt_r  <= 8'h00;
            tq.tq_tick <= 1'b1;
        end else begin
            div_cnt_r  <= div_cnt_r + 8'h01;
            tq.tq_tick <= 1'b0;
        end
    end

endmodule

// *** cbt_bit_timing_props.sv ***
// Port-level checks on the bit-timing and error-flag block.
// Assumes the bench keeps prescale at 0 or 1, so one bit spans at most 50 clocks.
module cbt_bit_timing_props (
    // Clock and reset
    input wire logic        ref_clk_in,
    input wire logic        reset_in,
    // Register port
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic        wr_en_in,
    input wire logic        rd_en_in,
    input wire logic [31:0] rd_data_out,
    // Bus and frame controller
    input wire logic        can_tx_out,
    input wire logic        tx_start_in,
    input wire logic        error_passive_in,
    input wire logic        err_now_in,
    input wire logic        sample_out,
    input wire logic        sampled_bit_out,
    input wire logic        bit_start_out,
    input wire logic        err_flag_out,
    input wire logic        retransmit_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic cfg_seen_r;

    default clocking cb_main @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);

    // Only an enabled configuration write may wake the engine
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in)
            cfg_seen_r <= 1'b0;
        else if (wr_en_in && addr_in == cbt_pkg::CFG_OFFSET && wr_data_in[cbt_pkg::CFG_EN_BIT])
            cfg_seen_r <= 1'b1;
    end

    idle_cfg_a: assert property (!cfg_seen_r |-> !sample_out && !bit_start_out && can_tx_out)
        else $error("bit timing ran before a configuration write");
    rd_idle_a: assert property (!rd_en_in |=> rd_data_out == 32'h0)
        else $error("read data outside the read answer cycle");
    rd_unmapped_a: assert property (rd_en_in && addr_in != cbt_pkg::CFG_OFFSET &&
        addr_in != cbt_pkg::STATUS_OFFSET |=> rd_data_out == 32'h0)
        else $error("unmapped read returned data");
    sample_pulse_a: assert property (sample_out |=> !sample_out)
        else $error("sampling pulse longer than one cycle");
    bit_apart_a: assert property (bit_start_out |=> !sample_out [*2])
        else $error("sampling point too close to bit start");
    sampled_sync_a: assert property ($changed(sampled_bit_out) |->
        (sample_out || $past(sample_out)) or (##1 sample_out))
        else $error("bit value changed away from the sampling point");
    flag_start_a: assert property (err_now_in && cfg_seen_r && !err_flag_out |-> ##[1:60] err_flag_out)
        else $error("error flag not started by the next bit");
    flag_active_a: assert property ($rose(err_flag_out) && !error_passive_in |-> !can_tx_out)
        else $error("active flag not dominant");
    flag_passive_a: assert property ($rose(err_flag_out) && error_passive_in |-> can_tx_out)
        else $error("passive flag not recessive");
    retx_cause_a: assert property ($rose(retransmit_out) |-> err_flag_out || $past(err_flag_out))
        else $error("resend requested without an error flag");
    retx_clear_a: assert property ($fell(retransmit_out) |-> $past(tx_start_in))
        else $error("resend request dropped without a new start");

    cover property ($rose(retransmit_out));
    cover property (sample_out && !sampled_bit_out);
    cover property ($rose(err_flag_out) && error_passive_in);
endmodule

// *** cbt_bus_node.sv ***
// Model of the other nodes and the shared wire they drive with the block.
// Assumes a recessive pull-up: the wire is dominant while any party drives low.
module cbt_bus_node #(
    parameter int LOOP_NS = 3
) (
    // Driving parties
    input  wire logic node_tx_in,
    input  wire logic other_level_in,
    // Level seen by every receiver
    output logic      bus_level_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Wired-AND with a transceiver loop delay; keeps showing the previous level for LOOP_NS after a change
    assign #(LOOP_NS) bus_level_out = node_tx_in & other_level_in;
endmodule

// *** testbench.sv ***
// Self-checking bench for the bit-timing and error-flag block.
// Assumes the bus model loops the block's own transmit level back to its receive pin.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        ref_clk_in       = 1'b0;
    logic        reset_in         = 1'b1;
    logic [7:0]  addr_in          = 8'h00;
    logic [31:0] wr_data_in       = 32'h0;
    logic        wr_en_in         = 1'b0;
    logic        rd_en_in         = 1'b0;
    logic        bus_idle_in      = 1'b0;
    logic        tx_active_in     = 1'b0;
    logic        tx_bit_in        = 1'b1;
    logic        tx_start_in      = 1'b0;
    logic        error_passive_in = 1'b0;
    logic        err_now_in       = 1'b0;
    logic        err_crc_in       = 1'b0;
    logic        ack_delim_in     = 1'b0;
    logic        other_level      = 1'b1;
    logic [31:0] rd_data_out;
    logic [31:0] rd_v;
    logic        can_rx_in, can_tx_out, sample_out, sampled_bit_out;
    logic        bit_start_out, err_flag_out, retransmit_out;
    // Fields per entry: propagation, first buffer, jump width, expected validity
    logic [15:0] tab [10] = '{16'h2311, 16'h1110, 16'h8841, 16'h3211, 16'h2210,
                              16'h0310, 16'h2230, 16'h2300, 16'h8850, 16'h2910};
    int          errors = 0, checks = 0, cyc = 0, t0, t1, t2;

    cbt_bit_timing i_dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
        .can_rx_in(can_rx_in), .can_tx_out(can_tx_out), .bus_idle_in(bus_idle_in),
        .tx_active_in(tx_active_in), .tx_bit_in(tx_bit_in), .tx_start_in(tx_start_in),
        .error_passive_in(error_passive_in), .err_now_in(err_now_in), .err_crc_in(err_crc_in),
        .ack_delim_in(ack_delim_in), .sample_out(sample_out), .sampled_bit_out(sampled_bit_out),
        .bit_start_out(bit_start_out), .err_flag_out(err_flag_out), .retransmit_out(retransmit_out));
    cbt_bus_node #(.LOOP_NS(3)) i_bus (.node_tx_in(can_tx_out), .other_level_in(other_level),
        .bus_level_out(can_rx_in));

    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) cyc <= cyc + 1;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] cfg(logic [7:0] ps, logic [3:0] prop, logic [3:0] pb1, logic [2:0] resync_jump_width);
        return {1'b1, 12'h000, resync_jump_width, pb1, prop, ps};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_en_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_en_in <= 1'b0;
        @(negedge ref_clk_in);
        d = rd_data_out;
    endtask

    // Event 0 bit start, 1 sampling point, 2 error flag; bounded so a dead engine cannot hang
    task automatic wait_ev(input int k, output int at);
        int n;
        n = 0;
        do begin
            @(negedge ref_clk_in);
            n++;
        end while (!(k == 0 ? bit_start_out === 1'b1 : k == 1 ? sample_out === 1'b1 : err_flag_out === 1'b1)
                   && n < 200);
        if (n >= 200)
            check("event_wait", 32'h0, 32'h1);
        at = cyc;
    endtask

    task automatic start(input logic [7:0] ps);
        int t;
        @(posedge ref_clk_in);
        reset_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        wr(cbt_pkg::CFG_OFFSET, cfg(ps, 4'h2, 4'h3, 3'h1));
        @(posedge ref_clk_in);
        bus_idle_in <= 1'b1;
        other_level <= 1'b0;
        wait_ev(1, t);
        @(negedge ref_clk_in);
        check("sof_bit", sampled_bit_out, 32'h0);
        @(posedge ref_clk_in);
        bus_idle_in <= 1'b0;
    endtask

    task automatic flag_run(input logic passive, input logic crc);
        int ts, te, n;
        wait_ev(0, ts);
        @(posedge ref_clk_in);
        error_passive_in <= passive;
        tx_active_in <= !passive;
        err_crc_in <= crc;
        err_now_in <= !crc;
        @(posedge ref_clk_in);
        err_crc_in <= 1'b0;
        err_now_in <= 1'b0;
        wait_ev(1, te);
        check("flag_early", err_flag_out, 32'h0);
        if (crc) begin
            wait_ev(1, te);
            check("crc_wait", err_flag_out, 32'h0);
            @(posedge ref_clk_in);
            ack_delim_in <= 1'b1;
            @(posedge ref_clk_in);
            ack_delim_in <= 1'b0;
        end
        wait_ev(2, te);
        n = crc ? 18 : 9;
        check("flag_start", te - ts >= n && te - ts <= n + 2, 32'h1);
        check("flag_level", can_tx_out, passive);
        n = 0;
        while (err_flag_out === 1'b1 && n < 200) begin
            @(negedge ref_clk_in);
            n++;
        end
        check("flag_len", n, 9 * cbt_pkg::ERR_FLAG_BITS);
        check("resend", retransmit_out, !passive);
        @(posedge ref_clk_in);
        tx_start_in <= 1'b1;
        @(posedge ref_clk_in);
        tx_start_in <= 1'b0;
        @(negedge ref_clk_in);
        check("resend_clr", retransmit_out, 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        errors++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        check("reset_outs", {can_tx_out, sampled_bit_out, sample_out, bit_start_out, err_flag_out,
              retransmit_out}, 32'h30);
        @(posedge ref_clk_in);
        reset_in <= 1'b0;
        rd(cbt_pkg::CFG_OFFSET, rd_v);
        check("cfg_reset", rd_v, cbt_pkg::CFG_RESET);
        foreach (tab[i]) begin
            wr(cbt_pkg::CFG_OFFSET, cfg(8'h00, tab[i][15:12], tab[i][11:8], tab[i][6:4]));
            wr(cbt_pkg::STATUS_OFFSET, 32'hffff_ffff);
            rd(cbt_pkg::CFG_OFFSET, rd_v);
            check("cfg_rb", rd_v, cfg(8'h00, tab[i][15:12], tab[i][11:8], tab[i][6:4]));
            rd(cbt_pkg::STATUS_OFFSET, rd_v);
            check("cfg_ok", rd_v[4:0], {tab[i][0], 1'b1, 3'h0});
        end
        rd(8'h08, rd_v);
        check("unmapped", rd_v, 32'h0);
        for (int i = 1; i >= 0; i--) begin
            start(8'(i));
            wait_ev(0, t0);
            @(posedge ref_clk_in);
            other_level <= 1'b1;
            wait_ev(1, t1);
            @(negedge ref_clk_in);
            check("rec_bit", sampled_bit_out, 32'h1);
            wait_ev(0, t2);
            check("sample_pos", t1 - t0, 6 * (i + 1));
            check("bit_len", t2 - t0, 9 * (i + 1));
        end
        // Late edge in the first buffer, then a second edge before sampling
        wait_ev(0, t0);
        repeat (2) @(posedge ref_clk_in);
        other_level <= 1'b0;
        @(posedge ref_clk_in);
        other_level <= 1'b1;
        @(posedge ref_clk_in);
        other_level <= 1'b0;
        wait_ev(0, t2);
        check("resync_cap", t2 - t0, 10);
        @(posedge ref_clk_in);
        other_level <= 1'b1;
        wait_ev(1, t1);
        @(posedge ref_clk_in);
        tx_active_in <= 1'b1;
        tx_bit_in <= 1'b0;
        @(negedge ref_clk_in);
        check("tx_hold", can_tx_out, 32'h1);
        wait_ev(1, t1);
        check("tx_bit", can_tx_out, 32'h0);
        @(posedge ref_clk_in);
        tx_bit_in <= 1'b1;
        flag_run(1'b0, 1'b0);
        flag_run(1'b1, 1'b1);
        // Early edge in the second buffer shortens that bit by the jump width
        wait_ev(0, t0);
        repeat (4) @(posedge ref_clk_in);
        other_level <= 1'b0;
        wait_ev(0, t2);
        check("resync_early", t2 - t0, 8);
        complete_run();
    end
endmodule

bind cbt_bit_timing cbt_bit_timing_props i_props (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .can_tx_out(can_tx_out), .tx_start_in(tx_start_in),
    .error_passive_in(error_passive_in), .err_now_in(err_now_in), .sample_out(sample_out),
    .sampled_bit_out(sampled_bit_out), .bit_start_out(bit_start_out), .err_flag_out(err_flag_out),
    .retransmit_out(retransmit_out));
